/* File: design/ecprv_top.sv */
// Peripheral-side ECP reverse transfer engine with APB registers
`timescale 1ns/1ps
module ecprv_top
  import ecprv_pkg::*;
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host-side pins
  input wire logic host_turnaround_pin,
  input wire logic session_active_pin,
  input wire logic host_ack_pin,
  // Data pins
  input wire logic [7:0] parallel_data_in,
  output logic [7:0] parallel_data_out,
  output logic [7:0] parallel_data_oe,
  // Peripheral outputs
  output logic peripheral_strobe_pin,
  output logic peripheral_ack_line,
  // Port data when not overridden
  input wire logic [7:0] port_data,
  // Interrupt, DMA request
  output logic irq,
  output logic transfer_request_flag
);
  import ecprv_pkg::*;

  // Engine state in one struct. The transfer register and the holding
  // register together are the only buffering: one byte on the pins and
  // one byte waiting. A further write before the first byte is done
  // simply overwrites the waiting byte, so software must pace itself
  // on the transfer request flag.
  typedef struct packed {
    ecprv_state_e fsm;
    logic [7:0] xfer;       // Transfer register byte
    logic xfer_ninth;       // Ninth bit of transfer register
    logic xfer_full;
    logic [7:0] hold;       // Holding register byte
    logic hold_ninth;
    logic hold_full;
    logic req;              // Transfer request flag
    logic idle;
    logic strobe;           // Peripheral strobe level
    logic [15:0] tmo;       // Idle timeout counter
    logic [7:0] setup;      // Setup clocks left
    logic [7:0] dout;
    logic [7:0] doe;
  } ecprv_eng_s;

  ecprv_eng_s st_r;
  ecprv_eng_s st_nxt;

  // Glue between the synchroniser, the register block and the engine
  ecprv_pins_s pins;           // Synchronised levels
  logic [2:0] rise;
  logic [2:0] fall;
  ecprv_edges_s edg;
  logic mode_en;
  logic [7:0] port_direction_reg;
  logic [15:0] pulse_timing_reg;
  logic hold_wr;
  logic hold_ninth_in;
  logic [7:0] hold_data;
  logic [ECPRV_EV_W-1:0] events;
  logic [3:0] live_flags;
  logic drive_en;

  // Pins from another domain pass three flops. The filter costs about
  // four clocks of latency on every host edge; at 20 MHz this is far
  // inside the host's own handshake pace, and it buys immunity to a
  // single sampled glitch on a long parallel cable.
  ecprv_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .raw({host_turnaround_pin, session_active_pin, host_ack_pin}),
    // Idle levels: turnaround high, session down, host ack low
    .rst_val(3'b100),
    .level(pins),
    .rise(rise),
    .fall(fall)
  );

  // Bit order of the synchroniser: turnaround, session, host ack
  assign edg = '{act_rise: rise[1], act_fall: fall[1], trn_rise: rise[2], trn_fall: fall[2]};

  // Registers and interrupt. The register block owns the mode bit, the
  // direction register and the timeout; the engine only sees their values
  // and a one-cycle holding write strobe with its ninth bit.
  ecprv_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .live_flags(live_flags),
    .events(events),
    .mode_en(mode_en),
    .port_direction_reg(port_direction_reg),
    .pulse_timing_reg(pulse_timing_reg),
    .hold_wr(hold_wr),
    .hold_ninth(hold_ninth_in),
    .hold_data(hold_data),
    .irq(irq)
  );

  // Events only count while the mode is on. Edges seen while the engine
  // is off are dropped rather than stored, so turning the mode on never
  // raises an interrupt for history that software cannot act on.
  always_comb begin
    events = '0;
    if (mode_en) begin
      events[ECPRV_EV_ACT_RISE] = edg.act_rise;
      events[ECPRV_EV_ACT_FALL] = edg.act_fall;
      events[ECPRV_EV_TRN_RISE] = edg.trn_rise;
      events[ECPRV_EV_TRN_FALL] = edg.trn_fall;
      // No legal termination exists here, so every session drop is
      // reported as illegal; software decides how to recover from it
      // and must not wait for a clean end of session.
      events[ECPRV_EV_ILLEGAL] = edg.act_fall;
    end
  end

  // Override only while host wants reverse data and session is up.
  // The override follows the filtered pin levels, so the pins are
  // released a few clocks after the host raises turnaround; the host
  // must not drive the data lines until then.
  assign drive_en = mode_en && !pins.host_turnaround_req && pins.session_active_in;

  // Software duty, not logic here: when the host raises turnaround,
  // software switches the controller back to forward transfers, lets
  // the lines settle and only then confirms the new direction to the
  // host. Nothing in this block times that wait.

  // Status view, top bit down: driving, transfer full, request, idle
  assign live_flags = {drive_en, st_r.xfer_full, st_r.req, st_r.idle};

  // Engine next state. Order matters below: the pin direction is worked
  // out first, then a holding write is applied, then the handshake state
  // may consume the held byte, and last of all a mode disable overrides
  // the state, strobe, request and idle flags so the engine can never be left mid-handshake.
  always_comb begin
    st_nxt = st_r;
    // Pin direction: override or follow direction register. A set
    // direction bit means input, hence the inversion into enables.
    if (drive_en) begin
      st_nxt.dout = st_r.xfer;
      st_nxt.doe = 8'hFF;
    end else begin
      st_nxt.dout = port_data;
      st_nxt.doe = ~port_direction_reg;
    end
    // A holding write always loads and drops the request. A write
    // while a byte is still held replaces it; there is no second slot.
    if (hold_wr) begin
      st_nxt.hold = hold_data;
      st_nxt.hold_ninth = hold_ninth_in;
      st_nxt.hold_full = 1'b1;
      st_nxt.req = 1'b0;
    end

    unique case (st_r.fsm)
      ECPRV_OFF: begin
        // Parked: strobe high, any held byte kept until entry, waiting for the mode bit
        st_nxt.strobe = 1'b1;
        if (mode_en) begin
          // Entry asks at once for the first byte and reports idle
          st_nxt.idle = 1'b1;
          st_nxt.req = 1'b1;
          st_nxt.hold_full = 1'b0;
          st_nxt.xfer_full = 1'b0;
          st_nxt.tmo = '0;
          st_nxt.fsm = ECPRV_WAIT;
        end
      end

      ECPRV_WAIT: begin
        // Transfer register is empty here; a held byte moves at once,
        // otherwise count towards idle until the timing register expires
        if (st_r.hold_full) begin
          // Move byte, then ask for the next one after a brief drop
          st_nxt.xfer = st_r.hold;
          st_nxt.xfer_ninth = st_r.hold_ninth;
          st_nxt.xfer_full = 1'b1;
          // A write landing now refills the holding register and wins
          st_nxt.hold_full = hold_wr;
          st_nxt.idle = 1'b0;
          st_nxt.req = !hold_wr;
          // Byte goes onto the pins now so the strobe trails it a clock
          if (drive_en) begin
            st_nxt.dout = st_r.hold;
          end
          st_nxt.tmo = '0;
          st_nxt.setup = 8'(ECPRV_SETUP_CYC);
          st_nxt.fsm = ECPRV_SETUP;
        end else if (!st_r.idle) begin
          // Count towards idle. The counter restarts whenever a byte
          // completes, so the interval runs from the end of the last
          // handshake rather than from the last write.
          if (st_r.tmo >= pulse_timing_reg) begin
            st_nxt.idle = 1'b1;
          end else begin
            st_nxt.tmo = st_r.tmo + 16'h0001;
          end
        end
      end

      ECPRV_SETUP: begin
        // One clock of data setup before strobe falls. Data and the ninth
        // bit went onto the pins when the byte moved, so this state only
        // spends the setup clocks.
        if (st_r.setup <= 8'h01) begin
          st_nxt.strobe = 1'b0;
          st_nxt.fsm = ECPRV_STRB;
        end else begin
          // Longer setup, should the setup constant be raised
          st_nxt.setup = st_r.setup - 8'h01;
        end
      end

      ECPRV_STRB: begin
        // Strobe is low; hold it until the filtered host ack goes high.
        // A host that never answers leaves us here until the mode is off.
        if (pins.host_ack_line) begin
          st_nxt.strobe = 1'b1;
          st_nxt.fsm = ECPRV_ACKLO;
        end
      end

      ECPRV_ACKLO: begin
        // Strobe is back high; the byte is done once host ack drops
        if (!pins.host_ack_line) begin
          // Byte done; reload if held, else wait
          st_nxt.xfer_full = 1'b0;
          st_nxt.tmo = '0;
          st_nxt.fsm = ECPRV_WAIT;
        end
      end
    endcase
    // Leaving the mode parks the engine. A held byte survives until the
    // next entry, which discards it so a new stream starts cleanly.
    if (!mode_en) begin
      st_nxt.fsm = ECPRV_OFF;
      st_nxt.strobe = 1'b1;
      st_nxt.req = 1'b0;
      st_nxt.idle = 1'b0;
    end
  end

  // Register engine state, frozen by clock enable. Reset parks the
  // engine with the strobe at its idle high level and nothing held.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{fsm: ECPRV_OFF, strobe: 1'b1, default: '0};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs from flops; ninth bit drives ack line only in mode.
  // The ack line is gated by the mode bit so that a stale ninth bit
  // from the last byte never reaches the pin once software leaves the
  // mode; the gate is a single AND after two flops, free of glitches
  // for all practical purposes since both change on the same edge.
  assign parallel_data_out = st_r.dout;
  assign parallel_data_oe = st_r.doe;
  assign peripheral_strobe_pin = st_r.strobe;
  assign peripheral_ack_line = st_r.xfer_ninth & mode_en;
  assign transfer_request_flag = st_r.req;

endmodule : ecprv_top

/* File: design/ecprv_pkg.sv */
// Package: register map, field layout, states and structs of the ECP reverse engine
package ecprv_pkg;

  // Register byte offsets (APB, one word each)
  localparam logic [7:0] ECPRV_CTRL_OFF = 8'h00; // Mode enable, port direction
  localparam logic [7:0] ECPRV_HOLD_OFF = 8'h04; // Holding register, ninth bit set
  localparam logic [7:0] ECPRV_HALT_OFF = 8'h08; // Holding register, ninth bit clear
  localparam logic [7:0] ECPRV_STAT_OFF = 8'h0C; // Live flags
  localparam logic [7:0] ECPRV_TIME_OFF = 8'h10; // Pulse timing register
  localparam logic [7:0] ECPRV_IRQS_OFF = 8'h14; // Sticky events, clear on read
  localparam logic [7:0] ECPRV_IRQM_OFF = 8'h18; // Interrupt mask

  // Control field positions
  localparam int ECPRV_CTRL_EN_BIT = 0;
  localparam int ECPRV_CTRL_DIR_LSB = 8;

  // Status field positions
  localparam int ECPRV_ST_IDLE_BIT = 0;
  localparam int ECPRV_ST_REQ_BIT = 1;
  localparam int ECPRV_ST_FULL_BIT = 2;
  localparam int ECPRV_ST_DRIVE_BIT = 3;

  // Event bit positions in status and mask
  localparam int ECPRV_EV_ACT_RISE = 0;
  localparam int ECPRV_EV_ACT_FALL = 1;
  localparam int ECPRV_EV_TRN_RISE = 2;
  localparam int ECPRV_EV_TRN_FALL = 3;
  localparam int ECPRV_EV_ILLEGAL = 4;
  localparam int ECPRV_EV_W = 5;

  // Reset values
  localparam logic [7:0] ECPRV_DIR_RST = 8'hFF;       // All pins input
  localparam logic [15:0] ECPRV_TIME_RST = 16'h0064;  // Idle timeout in clocks
  localparam logic [4:0] ECPRV_MASK_RST = 5'h00;

  // Cycles waited after data is valid before strobe falls
  localparam int ECPRV_SETUP_CYC = 1;

  // Handshake states
  typedef enum logic [2:0] {
    ECPRV_OFF, ECPRV_WAIT, ECPRV_SETUP, ECPRV_STRB, ECPRV_ACKLO
  } ecprv_state_e;

  // Pin-facing inputs after synchronisation
  typedef struct packed {
    logic host_turnaround_req;  // Low asks us to drive
    logic session_active_in;
    logic host_ack_line;
  } ecprv_pins_s;

  // Edge events, one-cycle pulses
  typedef struct packed {
    logic act_rise;
    logic act_fall;
    logic trn_rise;
    logic trn_fall;
  } ecprv_edges_s;

endpackage : ecprv_pkg

/* File: design/ecprv_sync.sv */
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module ecprv_sync
  import ecprv_pkg::*;
#(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Raw pins and reset level
  input wire logic [W-1:0] raw,
  input wire logic [W-1:0] rst_val,
  // Filtered level and edges
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  // All state in one struct
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] rs;
    logic [W-1:0] fl;
    logic init;
  } ecprv_sync_s;

  ecprv_sync_s st_r;
  ecprv_sync_s st_nxt;

  // Level changes only when stages two and three agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.rs = '0;
    st_nxt.fl = '0;
    if (!st_r.init) begin
      // Adopt idle level without edges after reset; the later stages
      // start at that level too, so no edge is seen before the pin moves
      st_nxt.lvl = rst_val;
      st_nxt.s2 = rst_val;
      st_nxt.s3 = rst_val;
      st_nxt.init = 1'b1;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (st_r.s2[i] == st_r.s3[i] && st_r.s3[i] != st_r.lvl[i]) begin
          st_nxt.lvl[i] = st_r.s3[i];
          st_nxt.rs[i] = st_r.s3[i];
          st_nxt.fl[i] = !st_r.s3[i];
        end
      end
    end
  end

  // Register, frozen by clock enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.lvl;
  assign rise = st_r.rs;
  assign fall = st_r.fl;

endmodule : ecprv_sync

/* File: design/ecprv_apb.sv */
// APB slave: register file, clear-on-read events and interrupt
`timescale 1ns/1ps
module ecprv_apb
  import ecprv_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Engine view
  input wire logic [3:0] live_flags,
  input wire logic [ECPRV_EV_W-1:0] events,
  output logic mode_en,
  output logic [7:0] port_direction_reg,
  output logic [15:0] pulse_timing_reg,
  output logic hold_wr,
  output logic hold_ninth,
  output logic [7:0] hold_data,
  output logic irq
);
  // Address check, used only for the slave error response
  function automatic logic ecprv_mapped(input logic [7:0] a);
    return a inside {ECPRV_CTRL_OFF, ECPRV_HOLD_OFF, ECPRV_HALT_OFF, ECPRV_STAT_OFF,
                     ECPRV_TIME_OFF, ECPRV_IRQS_OFF, ECPRV_IRQM_OFF};
  endfunction : ecprv_mapped

  typedef struct packed {
    logic en;
    logic [7:0] dir;
    logic [15:0] tim;
    logic [ECPRV_EV_W-1:0] sts;
    logic [ECPRV_EV_W-1:0] msk;
    logic [31:0] rd;
  } ecprv_regs_s;

  ecprv_regs_s st_r;
  ecprv_regs_s st_nxt;
  logic acc;

  // Zero-wait slave: access phase completes at once
  assign acc = psel && penable;
  assign pready = 1'b1;
  assign pslverr = acc && !ecprv_mapped(paddr);
  assign hold_wr = ce && acc && pwrite && (paddr == ECPRV_HOLD_OFF || paddr == ECPRV_HALT_OFF);
  assign hold_ninth = (paddr == ECPRV_HOLD_OFF);
  assign hold_data = pwdata[7:0];

  // Register writes, read data capture, sticky events
  always_comb begin
    st_nxt = st_r;
    if (acc && pwrite) begin
      unique case (paddr)
        ECPRV_CTRL_OFF: begin
          st_nxt.en = pwdata[ECPRV_CTRL_EN_BIT];
          st_nxt.dir = pwdata[ECPRV_CTRL_DIR_LSB +: 8];
        end
        ECPRV_TIME_OFF: st_nxt.tim = pwdata[15:0];
        ECPRV_IRQM_OFF: st_nxt.msk = pwdata[ECPRV_EV_W-1:0];
        default: ;
      endcase
    end
    if (psel && !penable && !pwrite) begin
      // Read data sampled in setup cycle
      unique case (paddr)
        ECPRV_CTRL_OFF: st_nxt.rd = {16'h0000, st_r.dir, 7'h00, st_r.en};
        ECPRV_STAT_OFF: st_nxt.rd = {28'h0000000, live_flags};
        ECPRV_TIME_OFF: st_nxt.rd = {16'h0000, st_r.tim};
        ECPRV_IRQS_OFF: st_nxt.rd = {27'h0000000, st_r.sts};
        ECPRV_IRQM_OFF: st_nxt.rd = {27'h0000000, st_r.msk};
        default: st_nxt.rd = 32'h00000000;
      endcase
    end
    // Read clears only what the setup cycle captured, so an event that
    // lands between setup and access is kept; a new event still wins
    if (acc && !pwrite && paddr == ECPRV_IRQS_OFF) begin
      st_nxt.sts = st_r.sts & ~st_r.rd[ECPRV_EV_W-1:0];
    end
    st_nxt.sts = st_nxt.sts | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{en: 1'b0, dir: ECPRV_DIR_RST, tim: ECPRV_TIME_RST, sts: '0,
                msk: ECPRV_MASK_RST, rd: '0};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rd;
  assign mode_en = st_r.en;
  assign port_direction_reg = st_r.dir;
  assign pulse_timing_reg = st_r.tim;
  assign irq = |(st_r.sts & st_r.msk);

endmodule : ecprv_apb

/* File: test/ecprv_monitor.sv */
// Checker: handshake, pin-drive and request relations at the engine's ports
`timescale 1ns/1ps
module ecprv_monitor
  import ecprv_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  // Pins
  input wire logic host_turnaround_pin,
  input wire logic session_active_pin,
  input wire logic host_ack_pin,
  input wire logic [7:0] parallel_data_out,
  input wire logic [7:0] parallel_data_oe,
  input wire logic peripheral_strobe_pin,
  input wire logic peripheral_ack_line,
  input wire logic transfer_request_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bench keeps the port direction at all-input, so release means no enables
  property p_trn_off; host_turnaround_pin [*8] |-> parallel_data_oe == 8'h00; endproperty
  a_trn_off: assert property (p_trn_off) else $error("pins driven, turnaround high");
  property p_act_off; !session_active_pin [*8] |-> parallel_data_oe == 8'h00; endproperty
  a_act_off: assert property (p_act_off) else $error("pins driven, session inactive");
  // Data and ninth bit settle a clock before the strobe falls
  property p_setup;
    $fell(peripheral_strobe_pin) |->
      $stable(parallel_data_out) && $stable(peripheral_ack_line);
  endproperty
  a_setup: assert property (p_setup) else $error("strobe fell with unsettled data");
  property p_keep;
    !peripheral_strobe_pin && !$past(peripheral_strobe_pin) |->
      $stable(parallel_data_out) && $stable(peripheral_ack_line);
  endproperty
  a_keep: assert property (p_keep) else $error("data moved while strobe low");
  property p_drive; !peripheral_strobe_pin |-> parallel_data_oe == 8'hFF; endproperty
  a_drive: assert property (p_drive) else $error("strobe low with pins undriven");
  // Synchroniser has three flops, so host ack must be seen three clocks back
  property p_release; $rose(peripheral_strobe_pin) |-> $past(host_ack_pin, 3); endproperty
  a_release: assert property (p_release) else $error("strobe released without ack");
  property p_hold_wr;
    psel && penable && pwrite && paddr == ECPRV_HOLD_OFF |=> !transfer_request_flag;
  endproperty
  a_hold_wr: assert property (p_hold_wr) else $error("request kept on hold write");
  property p_halt_wr;
    psel && penable && pwrite && paddr == ECPRV_HALT_OFF |=> !transfer_request_flag;
  endproperty
  a_halt_wr: assert property (p_halt_wr) else $error("request kept on alt write");
  // Main scenarios reached
  c_fall: cover property ($fell(peripheral_strobe_pin));
  c_rise: cover property ($rose(peripheral_strobe_pin));
  c_halt: cover property (psel && penable && pwrite && paddr == ECPRV_HALT_OFF);
endmodule : ecprv_monitor

bind ecprv_top ecprv_monitor u_ecprv_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .host_turnaround_pin(host_turnaround_pin),
  .session_active_pin(session_active_pin), .host_ack_pin(host_ack_pin),
  .parallel_data_out(parallel_data_out), .parallel_data_oe(parallel_data_oe),
  .peripheral_strobe_pin(peripheral_strobe_pin), .peripheral_ack_line(peripheral_ack_line),
  .transfer_request_flag(transfer_request_flag)
);

/* File: test/ecprv_host_model.sv */
// Host side model: answers the peripheral strobe on the ack line
`timescale 1ns/1ps
module ecprv_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Handshake
  input wire logic peripheral_strobe_pin,
  input wire logic [3:0] dly,
  output logic host_ack_pin
);
  logic [3:0] cnt_r; // Clocks waited before answering
  // Raise ack after strobe falls, drop it after strobe rises; dly sets the pace
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_ack_pin <= 1'b0;
      cnt_r <= 4'h0;
    end else if (host_ack_pin == peripheral_strobe_pin) begin
      if (cnt_r >= dly) begin
        host_ack_pin <= !host_ack_pin;
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end else begin
      cnt_r <= 4'h0;
    end
  end
endmodule : ecprv_host_model

/* File: test/tb_ecprv_top.sv */
// Testbench: APB register, transfer handshake and pin event checks
`timescale 1ns/1ps
module tb_ecprv_top;
  import ecprv_pkg::*;
  localparam int TMO = 24; // Short idle timeout keeps the run brief
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic trn = 1, act = 0, pready, pslverr, irq, req, strobe, ack9, hack;
  logic [7:0] paddr = 0, dout, doe, a, d;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] dly = 0;
  logic tv[4] = '{1, 0, 0, 0}; // Turnaround steps
  logic av[4] = '{1, 1, 0, 1}; // Session steps
  int seed = 80, n_mismatch = 0, n_compared = 0, k;
  always #25 pclk = ~pclk;
  ecprv_top u_ecprv_top (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_turnaround_pin(trn), .session_active_pin(act),
    .host_ack_pin(hack), .parallel_data_in(8'h00), .parallel_data_out(dout),
    .parallel_data_oe(doe), .peripheral_strobe_pin(strobe), .peripheral_ack_line(ack9),
    .port_data(8'h3C), .irq(irq), .transfer_request_flag(req));
  ecprv_host_model u_ecprv_host_model (.pclk(pclk), .presetn(presetn),
    .peripheral_strobe_pin(strobe), .dly(dly), .host_ack_pin(hack));
  // Expected sticky events for one step of the two host pins
  function automatic logic [31:0] ev_of(input logic t0, t1, a0, a1);
    ev_of = 32'h0;
    ev_of[ECPRV_EV_ACT_RISE] = !a0 && a1;
    ev_of[ECPRV_EV_ACT_FALL] = a0 && !a1;
    ev_of[ECPRV_EV_TRN_RISE] = !t0 && t1;
    ev_of[ECPRV_EV_TRN_FALL] = t0 && !t1;
    ev_of[ECPRV_EV_ILLEGAL] = a0 && !a1;
  endfunction : ev_of
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // One APB transfer; called just after a rising edge, waits on pready
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int i;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
    if (i == 50) begin
      n_mismatch++;
      wrap_up();
    end
  endtask : apb
  task automatic wait_strobe(input logic lvl);
    int i;
    for (i = 0; i < 300 && strobe !== lvl; i++) @(posedge pclk);
    if (i == 300) begin
      n_mismatch++;
      wrap_up();
    end
  endtask : wait_strobe
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, ECPRV_CTRL_OFF, 0); chk("ctrl", 32'h0000FF00, rd);
    apb(0, ECPRV_TIME_OFF, 0); chk("time", 32'(ECPRV_TIME_RST), rd);
    apb(0, 8'h1C, 0); chk("slverr", 32'h1, {31'h0, err});
    apb(1, ECPRV_TIME_OFF, TMO);
    apb(1, ECPRV_IRQM_OFF, 32'h1F);
    trn <= 0; act <= 1;
    repeat (8) @(posedge pclk);
    apb(1, ECPRV_CTRL_OFF, 32'h0000FF01);
    apb(0, ECPRV_STAT_OFF, 0); chk("stat", 32'h0B, rd);
    chk("req", 32'h1, {31'h0, req});
    apb(0, ECPRV_IRQS_OFF, 0);
    $display("done: entry");
    // Bytes with extremes first, then random; next write overlaps the ack
    for (k = 0; k < 8; k++) begin
      a = (k == 0 || $random(seed) % 2) ? ECPRV_HALT_OFF : ECPRV_HOLD_OFF;
      d = k == 0 ? 8'hFF : k == 1 ? 8'h00 : 8'($random(seed));
      dly <= 4'($random(seed));
      apb(1, a, {24'h0, d});
      wait_strobe(0);
      chk("data", {24'h0, d}, {24'h0, dout});
      chk("ninth", {31'h0, a == ECPRV_HOLD_OFF}, {31'h0, ack9});
      wait_strobe(1);
    end
    apb(0, ECPRV_STAT_OFF, 0); chk("busy", 32'h0, {31'h0, rd[ECPRV_ST_IDLE_BIT]});
    repeat (TMO + 30) @(posedge pclk);
    apb(0, ECPRV_STAT_OFF, 0); chk("idle", 32'h1, {31'h0, rd[ECPRV_ST_IDLE_BIT]});
    $display("done: transfer");
    for (k = 0; k < 4; k++) begin
      trn <= tv[k]; act <= av[k];
      repeat (10) @(posedge pclk);
      chk("oe", (!tv[k] && av[k]) ? 32'hFF : 32'h0, {24'h0, doe});
      chk("pin data", (!tv[k] && av[k]) ? {24'h0, d} : 32'h3C, {24'h0, dout});
      chk("irq", 32'h1, {31'h0, irq});
      apb(0, ECPRV_IRQS_OFF, 0);
      chk("events", ev_of(k ? tv[k-1] : 1'b0, tv[k], k ? av[k-1] : 1'b1, av[k]), rd);
      chk("irq clr", 32'h0, {31'h0, irq});
    end
    apb(1, ECPRV_IRQM_OFF, 0);
    act <= 0;
    repeat (10) @(posedge pclk);
    chk("masked", 32'h0, {31'h0, irq});
    apb(0, ECPRV_IRQS_OFF, 0); chk("sticky", ev_of(0, 0, 1, 0), rd);
    $display("done: events");
    // Host raises turnaround; software leaves the mode, then settles
    trn <= 1;
    repeat (10) @(posedge pclk);
    apb(1, ECPRV_CTRL_OFF, 32'h0000FF00);
    repeat (10) @(posedge pclk);
    apb(0, ECPRV_STAT_OFF, 0); chk("parked", 32'h0, rd);
    chk("req off", 32'h0, {31'h0, req});
    chk("ack off", 32'h0, {31'h0, ack9});
    chk("pins off", 32'h0, {24'h0, doe});
    $display("done: turnaround");
    wrap_up();
  end
endmodule : tb_ecprv_top
